// ---- include/can_irq_defines.svh ----
// Purpose: Named constants for the interrupt aggregation block.
// Assumes: Included by bare name from design and bench files.
// Notes: Bit positions of the main enable vector and flag vector match.
`ifndef CAN_IRQ_DEFINES_SVH
`define CAN_IRQ_DEFINES_SVH

`define FIFO_COUNT 32
`define MAIN_COUNT 13
// Main flag and enable positions.
`define MAIN_RX 0
`define MAIN_TX 1
`define MAIN_RXOV 2
`define MAIN_TXAT 3
`define MAIN_TEF 4
`define MAIN_IVM 5
`define MAIN_WAK 6
`define MAIN_CERR 7
`define MAIN_MOD 8
`define MAIN_TBC 9
`define MAIN_SERR 10
`define MAIN_SPI 11
`define MAIN_ECC 12
`define RX_GROUP 13'h0005
`define TX_GROUP 13'h001a
`define INFO_GROUP 13'h1fe0
// Interrupt code values.
`define CODE_SYSTEM_ERROR 7'h45
`define CODE_NONE 7'h40
// Error counter thresholds.
`define WARN_LIMIT 9'h060
`define PASSIVE_LIMIT 9'h080
`define BUSOFF_LIMIT 9'h100
`define RESET_FLAGS 32'h0000_0000
`define RESERVED_BIT0 32'hffff_fffe

`endif

// ---- include/can_irq_pkg.sv ----
// Purpose: Types shared by the interrupt aggregation block and its bench.
// Assumes: Nothing beyond the defines header.
// Notes: Enums carry no explicit codes.
package can_irq_pkg;
   typedef enum {ERR_ACTIVE, ERR_PASSIVE, ERR_BUSOFF} err_state_e;
   typedef enum {RX_IDLE, RX_SAVING, RX_COMMIT} rx_state_e;
   typedef logic [4:0] fifo_index_t;
   typedef logic [6:0] code_t;
endpackage

// ---- hdl/can_fd_interrupt_aggregator.sv ----
// Purpose: Layered interrupt aggregation and system-error reaction of a CAN FD controller.
// Assumes: All inputs synchronous to clk; event inputs are one-cycle pulses, status inputs levels.
// Notes: Host clears arrive as one-cycle pulse masks; a set in the same cycle wins.
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_defines.svh"

module can_fd_interrupt_aggregator (
   input wire logic clk,
   input wire logic rst,
   // Per-FIFO configuration, status levels and enables.
   input wire logic [31:0] fifoIsTx,
   input wire logic [31:0] rxFifoFullFlag,
   input wire logic [31:0] rxFifoHalfFlag,
   input wire logic [31:0] rxFifoNonemptyFlag,
   input wire logic [31:0] rxFullEnable,
   input wire logic [31:0] rxHalfEnable,
   input wire logic [31:0] rxNonemptyEnable,
   input wire logic [31:0] txFifoNotFullFlag,
   input wire logic [31:0] txFifoHalfEmptyFlag,
   input wire logic [31:0] txFifoEmptyFlag,
   input wire logic [31:0] txNotFullEnable,
   input wire logic [31:0] txHalfEmptyEnable,
   input wire logic [31:0] txEmptyEnable,
   input wire logic queueNotFullFlag,
   input wire logic queueEmptyFlag,
   input wire logic queueNotFullEnable,
   input wire logic queueEmptyEnable,
   // Overrun and attempt events with host clear masks.
   input wire logic rxMessageDone,
   input wire can_irq_pkg::fifo_index_t rxMessageFifo,
   input wire logic [31:0] rxOverrunClear,
   input wire logic txRetriesExhausted,
   input wire can_irq_pkg::fifo_index_t txAttemptFifo,
   input wire logic [31:0] txAttemptClear,
   input wire logic [31:0] rxOverrunEnable,
   input wire logic [31:0] txAttemptEnable,
   // Transmit event FIFO.
   input wire logic eventFifoFullFlag,
   input wire logic eventFifoHalfFlag,
   input wire logic eventFifoNonemptyFlag,
   input wire logic eventFifoOverrunEvent,
   input wire logic eventFifoOverrunClear,
   input wire logic [3:0] eventFifoEnable,
   // SPI integrity and memory check.
   input wire logic spiFormatErrorEvent,
   input wire logic spiChecksumErrorEvent,
   input wire logic spiFormatErrorClear,
   input wire logic spiChecksumErrorClear,
   input wire logic spiFormatErrorEnable,
   input wire logic spiChecksumErrorEnable,
   input wire logic singleBitErrorEvent,
   input wire logic doubleBitErrorEvent,
   input wire logic singleBitErrorClear,
   input wire logic doubleBitErrorClear,
   input wire logic singleBitErrorEnable,
   input wire logic doubleBitErrorEnable,
   // Main event sources.
   input wire logic frameEnd,
   input wire logic dlcMismatch,
   input wire logic errorFrameSent,
   input wire logic esiReceived,
   input wire logic sleepMode,
   input wire logic busActivity,
   input wire logic [8:0] txErrorCount,
   input wire logic [7:0] rxErrorCount,
   input wire logic [2:0] currentOperatingMode,
   input wire logic timeBaseWrap,
   input wire logic [12:0] mainEnable,
   input wire logic [12:0] mainClear,
   // Receive frame timing, system error sources and transmit blocking.
   input wire logic crcFieldStart,
   input wire logic eofBit7Start,
   input wire logic storeDone,
   input wire logic txMabUnderflow,
   input wire logic eccDataError,
   input wire logic errorToListenOnlySelect,
   input wire logic txBitstream,
   input wire logic [31:0] transmitRequest,
   // Registered outputs.
   output logic [31:0] combinedReceiveFlags,
   output logic [31:0] combinedTransmitFlags,
   output logic [31:0] combinedReceiveOverrunFlags,
   output logic [31:0] combinedTransmitAttemptFlags,
   output logic [12:0] mainFlags,
   output logic spiFormatErrorFlag,
   output logic spiChecksumErrorFlag,
   output logic singleBitErrorFlag,
   output logic doubleBitErrorFlag,
   output logic eventFifoOverrunFlag,
   output can_irq_pkg::code_t interruptCodeField,
   output logic rxInterrupt,
   output logic txInterrupt,
   output logic infoInterrupt,
   output logic fifoStatusUpdate,
   output logic frameDiscard,
   output logic restrictedMode,
   output logic listenOnlyMode,
   output logic busTransmitPin,
   output logic [31:0] transmitRequestGated
);
   import can_irq_pkg::*;

   logic [31:0] rxComb, txComb, ovrSet, atSet;
   logic [31:0] ovr_d, at_d;
   logic [12:0] main_d;
   logic evOvr_d, fmt_d, crc_d, sec_d, ded_d;
   logic ivm_d, wak_d, cerr_d, mod_d, tbc_d, serr_d;
   logic ivmSet, cerrSet, serrSet;
   logic rxOverflow, txBlock_d;
   logic warn_q;
   logic warnNow;
   logic [2:0] mode_q;
   err_state_e errNow, err_q;
   rx_state_e rxState_q;
   logic [12:0] sticky_q;

   // Per-FIFO enabled OR; bit zero is the queue on the transmit side only.
   always_comb begin
      rxComb = (rxFifoFullFlag & rxFullEnable) | (rxFifoHalfFlag & rxHalfEnable)
         | (rxFifoNonemptyFlag & rxNonemptyEnable);
      rxComb = rxComb & ~fifoIsTx & `RESERVED_BIT0;
      txComb = (txFifoNotFullFlag & txNotFullEnable) | (txFifoHalfEmptyFlag & txHalfEmptyEnable)
         | (txFifoEmptyFlag & txEmptyEnable);
      txComb = txComb & fifoIsTx & `RESERVED_BIT0;
      txComb[0] = (queueNotFullFlag & queueNotFullEnable)
         | (queueEmptyFlag & queueEmptyEnable);
   end

   // Sticky per-FIFO overrun and attempt flags; a set outranks a clear in the same cycle.
   always_comb begin
      ovrSet = `RESET_FLAGS;
      atSet = `RESET_FLAGS;
      if (rxMessageDone && rxFifoFullFlag[rxMessageFifo] && !fifoIsTx[rxMessageFifo]) begin
         ovrSet[rxMessageFifo] = 1'b1;
      end
      if (txRetriesExhausted) begin
         atSet[txAttemptFifo] = 1'b1;
      end
      ovr_d = ((combinedReceiveOverrunFlags & ~rxOverrunClear) | ovrSet)
         & `RESERVED_BIT0;
      at_d = (combinedTransmitAttemptFlags & ~txAttemptClear) | atSet;
   end

   // Level flags come straight from the FIFO status; no clear input reaches them.
   always_ff @(posedge clk) begin
      if (rst) begin
         combinedReceiveFlags <= `RESET_FLAGS;
         combinedTransmitFlags <= `RESET_FLAGS;
      end else begin
         combinedReceiveFlags <= rxComb;
         combinedTransmitFlags <= txComb;
      end
   end

   // Overrun and attempt registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         combinedReceiveOverrunFlags <= `RESET_FLAGS;
         combinedTransmitAttemptFlags <= `RESET_FLAGS;
      end else begin
         combinedReceiveOverrunFlags <= ovr_d;
         combinedTransmitAttemptFlags <= at_d;
      end
   end

   // Device-level sticky flags for SPI integrity, memory check and event FIFO overrun.
   always_comb begin
      evOvr_d = (eventFifoOverrunFlag & ~eventFifoOverrunClear) | eventFifoOverrunEvent;
      fmt_d = (spiFormatErrorFlag & ~spiFormatErrorClear) | spiFormatErrorEvent;
      crc_d = (spiChecksumErrorFlag & ~spiChecksumErrorClear) | spiChecksumErrorEvent;
      sec_d = (singleBitErrorFlag & ~singleBitErrorClear) | singleBitErrorEvent;
      ded_d = (doubleBitErrorFlag & ~doubleBitErrorClear) | doubleBitErrorEvent;
   end

   // Sticky device flag registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         eventFifoOverrunFlag <= 1'b0;
         spiFormatErrorFlag <= 1'b0;
         spiChecksumErrorFlag <= 1'b0;
         singleBitErrorFlag <= 1'b0;
         doubleBitErrorFlag <= 1'b0;
      end else begin
         eventFifoOverrunFlag <= evOvr_d;
         spiFormatErrorFlag <= fmt_d;
         spiChecksumErrorFlag <= crc_d;
         singleBitErrorFlag <= sec_d;
         doubleBitErrorFlag <= ded_d;
      end
   end

   // Error state derived from the counters; warning is tracked apart from the state.
   always_comb begin
      warnNow = (txErrorCount >= `WARN_LIMIT)
         || ({1'b0, rxErrorCount} >= `WARN_LIMIT);
      if (txErrorCount >= `BUSOFF_LIMIT) begin
         errNow = ERR_BUSOFF;
      end else if (txErrorCount >= `PASSIVE_LIMIT || {1'b0, rxErrorCount} >= `PASSIVE_LIMIT) begin
         errNow = ERR_PASSIVE;
      end else begin
         errNow = ERR_ACTIVE;
      end
   end

   // Crossing detection: warning rise, or any change of state, including back to active.
   always_ff @(posedge clk) begin
      if (rst) begin
         warn_q <= 1'b0;
         err_q <= ERR_ACTIVE;
         mode_q <= 3'h0;
      end else begin
         warn_q <= warnNow;
         err_q <= errNow;
         mode_q <= currentOperatingMode;
      end
   end

   // Event conditions of the sticky main flags.
   always_comb begin
      ivmSet = frameEnd && (dlcMismatch || errorFrameSent) && !esiReceived;
      cerrSet = (warnNow && !warn_q) || (errNow != err_q);
      serrSet = rxOverflow || txMabUnderflow || eccDataError;
      ivm_d = (sticky_q[`MAIN_IVM] & ~mainClear[`MAIN_IVM]) | ivmSet;
      wak_d = (sticky_q[`MAIN_WAK] & ~mainClear[`MAIN_WAK])
         | (sleepMode & busActivity);
      cerr_d = (sticky_q[`MAIN_CERR] & ~mainClear[`MAIN_CERR]) | cerrSet;
      mod_d = (sticky_q[`MAIN_MOD] & ~mainClear[`MAIN_MOD])
         | (currentOperatingMode != mode_q);
      tbc_d = (sticky_q[`MAIN_TBC] & ~mainClear[`MAIN_TBC]) | timeBaseWrap;
      serr_d = (sticky_q[`MAIN_SERR] & ~mainClear[`MAIN_SERR]) | serrSet;
   end

   // Main flag vector: read-only ORs plus the host-cleared sticky flags.
   always_comb begin
      main_d = 13'h0000;
      main_d[`MAIN_RX] = |rxComb;
      main_d[`MAIN_TX] = |txComb;
      main_d[`MAIN_RXOV] = |ovr_d;
      main_d[`MAIN_TXAT] = |at_d;
      main_d[`MAIN_TEF] = (eventFifoFullFlag & eventFifoEnable[0])
         | (eventFifoHalfFlag & eventFifoEnable[1])
         | (eventFifoNonemptyFlag & eventFifoEnable[2]) | (evOvr_d & eventFifoEnable[3]);
      main_d[`MAIN_IVM] = ivm_d;
      main_d[`MAIN_WAK] = wak_d;
      main_d[`MAIN_CERR] = cerr_d;
      main_d[`MAIN_MOD] = mod_d;
      main_d[`MAIN_TBC] = tbc_d;
      main_d[`MAIN_SERR] = serr_d;
      main_d[`MAIN_SPI] = (fmt_d & spiFormatErrorEnable)
         | (crc_d & spiChecksumErrorEnable);
      main_d[`MAIN_ECC] = (sec_d & singleBitErrorEnable)
         | (ded_d & doubleBitErrorEnable);
   end

   // Only the host-cleared positions of sticky_q are read back; the rest just mirror main_d.
   always_ff @(posedge clk) begin
      if (rst) begin
         sticky_q <= 13'h0000;
         mainFlags <= 13'h0000;
      end else begin
         sticky_q <= main_d;
         mainFlags <= main_d;
      end
   end

   // Module requests are built from next-state flags so they track within one clock.
   always_ff @(posedge clk) begin
      if (rst) begin
         rxInterrupt <= 1'b0;
         txInterrupt <= 1'b0;
         infoInterrupt <= 1'b0;
      end else begin
         rxInterrupt <= |(main_d & mainEnable & `RX_GROUP);
         txInterrupt <= |(main_d & mainEnable & `TX_GROUP);
         infoInterrupt <= |(main_d & mainEnable & `INFO_GROUP);
      end
   end

   // The code shows the system error while its flag stands and drops with the clear.
   always_ff @(posedge clk) begin
      if (rst) begin
         interruptCodeField <= `CODE_NONE;
      end else if (serr_d) begin
         interruptCodeField <= `CODE_SYSTEM_ERROR;
      end else begin
         interruptCodeField <= `CODE_NONE;
      end
   end

   // Receive sequencing: saving starts by the CRC field, status commits at EOF bit seven,
   // and a new frame reaching its CRC field while the old one is still being stored overflows.
   always_comb begin
      rxOverflow = (rxState_q == RX_COMMIT) && crcFieldStart && !storeDone;
   end

   // Receive sequencer and its strobes.
   always_ff @(posedge clk) begin
      if (rst) begin
         rxState_q <= RX_IDLE;
         fifoStatusUpdate <= 1'b0;
         frameDiscard <= 1'b0;
      end else begin
         fifoStatusUpdate <= 1'b0;
         frameDiscard <= rxOverflow;
         case (rxState_q)
            RX_IDLE: begin
               if (crcFieldStart) begin
                  rxState_q <= RX_SAVING;
               end
            end
            RX_SAVING: begin
               if (eofBit7Start) begin
                  fifoStatusUpdate <= 1'b1;
                  rxState_q <= RX_COMMIT;
               end
            end
            RX_COMMIT: begin
               // The stored frame finishes first; the overflowing one is dropped.
               if (storeDone && crcFieldStart) begin
                  rxState_q <= RX_SAVING;
               end else if (storeDone) begin
                  rxState_q <= RX_IDLE;
               end
            end
            default: begin
               rxState_q <= RX_IDLE;
            end
         endcase
      end
   end

   // Data consistency errors freeze the transmitter until the system error is cleared.
   always_comb begin
      txBlock_d = txMabUnderflow || eccDataError
         || ((restrictedMode || listenOnlyMode) && !mainClear[`MAIN_SERR]);
   end

   // While blocked the pin stays recessive and requests drop.
   always_ff @(posedge clk) begin
      if (rst) begin
         restrictedMode <= 1'b0;
         listenOnlyMode <= 1'b0;
         busTransmitPin <= 1'b1;
         transmitRequestGated <= `RESET_FLAGS;
      end else begin
         restrictedMode <= txBlock_d && !errorToListenOnlySelect;
         listenOnlyMode <= txBlock_d && errorToListenOnlySelect;
         busTransmitPin <= txBlock_d ? 1'b1 : txBitstream;
         transmitRequestGated <= txBlock_d ? `RESET_FLAGS : transmitRequest;
      end
   end

endmodule
`default_nettype wire

// ---- bench/host_model.sv ----
// Purpose: Host side model that issues the write-to-clear pulses.
// Assumes: Called at a falling edge; each clear stands for one cycle.
// Notes: Level flags get no clear path, as the host cannot clear them.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk,
   output logic [12:0] mainClear,
   output logic [31:0] rxOverrunClear,
   output logic [31:0] txAttemptClear,
   output logic [4:0] devClear
);
   // Idle with no clear pending.
   initial begin
      mainClear = 13'h0;
      rxOverrunClear = 32'h0;
      txAttemptClear = 32'h0;
      devClear = 5'h0;
   end
   // One cycle only, so a fresh set after the clear is not masked.
   task automatic clear(input logic [12:0] m, input logic [31:0] ov, input logic [31:0] at, input logic [4:0] d);
      mainClear = m;
      rxOverrunClear = ov;
      txAttemptClear = at;
      devClear = d;
      @(negedge clk);
      mainClear = 13'h0;
      rxOverrunClear = 32'h0;
      txAttemptClear = 32'h0;
      devClear = 5'h0;
   endtask
endmodule
`default_nettype wire

// ---- bench/can_irq_props.sv ----
// Purpose: Port checks of the interrupt aggregation block.
// Assumes: Outputs follow their causes by one clock edge.
// Notes: Bound into every instance of the block.
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_defines.svh"
module can_irq_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] rxOverrunClear,
   input wire logic crcFieldStart,
   input wire logic eofBit7Start,
   input wire logic storeDone,
   input wire logic txMabUnderflow,
   input wire logic eccDataError,
   input wire logic [12:0] mainEnable,
   input wire logic [12:0] mainClear,
   input wire logic [31:0] combinedReceiveFlags,
   input wire logic [31:0] combinedTransmitFlags,
   input wire logic [31:0] combinedReceiveOverrunFlags,
   input wire logic [31:0] combinedTransmitAttemptFlags,
   input wire logic [12:0] mainFlags,
   input wire can_irq_pkg::code_t interruptCodeField,
   input wire logic rxInterrupt,
   input wire logic infoInterrupt,
   input wire logic fifoStatusUpdate,
   input wire logic frameDiscard,
   input wire logic busTransmitPin,
   input wire logic [31:0] transmitRequestGated
);
   import can_irq_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [12:0] enPrev;
   logic [31:0] ovPrev;
   // Last-cycle causes in flops, so no past value of an expression is needed.
   always_ff @(posedge clk) begin
      enPrev <= mainEnable;
      ovPrev <= combinedReceiveOverrunFlags & ~rxOverrunClear;
   end
   sequence s_frame_valid;
      crcFieldStart ##[1:8] eofBit7Start;
   endsequence
   sequence s_early_frame;
      eofBit7Start ##1 (crcFieldStart && !storeDone);
   endsequence
   a_rx_bit_zero: assert property (!combinedReceiveFlags[0] && !combinedReceiveOverrunFlags[0])
      else $error("receive bit zero set");
   a_overrun_hold: assert property (!$past(rst) |-> (ovPrev & ~combinedReceiveOverrunFlags) == 32'h0)
      else $error("overrun flag lost without clear");
   a_main_or: assert property (mainFlags[3:0] == {|combinedTransmitAttemptFlags,
      |combinedReceiveOverrunFlags, |combinedTransmitFlags, |combinedReceiveFlags}) else $error("main flag not OR");
   a_rx_irq: assert property (!$past(rst) |-> rxInterrupt == ((mainFlags[0] && enPrev[0]) ||
      (mainFlags[2] && enPrev[2]))) else $error("receive interrupt wrong");
   a_info_irq: assert property (!$past(rst) |-> infoInterrupt == |(mainFlags[12:5] & enPrev[12:5]))
      else $error("information interrupt wrong");
   a_code_set: assert property ($rose(mainFlags[10]) |-> interruptCodeField == `CODE_SYSTEM_ERROR)
      else $error("system error code missing");
   a_code_clear: assert property (mainClear[10] && !(txMabUnderflow || eccDataError || crcFieldStart)
      |=> !mainFlags[10] && interruptCodeField == `CODE_NONE) else $error("system error not cleared");
   a_pin_block: assert property ((txMabUnderflow || eccDataError) |=> busTransmitPin
      && transmitRequestGated == 32'h0) else $error("transmit not blocked");
   a_commit_late: assert property (s_frame_valid |-> ##[1:2] fifoStatusUpdate)
      else $error("status update missing");
   a_discard_new: assert property (s_early_frame |-> ##[1:2] (frameDiscard && mainFlags[10]))
      else $error("overflow frame not discarded");
endmodule
bind can_fd_interrupt_aggregator can_irq_props props (.*);
`default_nettype wire

// ---- bench/can_fd_interrupt_aggregator_tb.sv ----
// Purpose: Self-checking bench of the interrupt aggregation block.
// Assumes: Inputs change at the falling edge; outputs settle at the rising one.
// Notes: Host clears come from the host model.
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_defines.svh"
module can_fd_interrupt_aggregator_tb;
   import can_irq_pkg::*;
   logic clk, rst, queueNotFullFlag, queueEmptyFlag, queueNotFullEnable, queueEmptyEnable, rxMessageDone;
   logic txRetriesExhausted, eventFifoFullFlag, eventFifoHalfFlag, eventFifoNonemptyFlag, eventFifoOverrunEvent;
   logic spiFormatErrorEvent, spiChecksumErrorEvent, spiFormatErrorEnable, spiChecksumErrorEnable;
   logic singleBitErrorEvent, doubleBitErrorEvent, singleBitErrorEnable, doubleBitErrorEnable, frameEnd;
   logic dlcMismatch, errorFrameSent, esiReceived, sleepMode, busActivity, timeBaseWrap, crcFieldStart;
   logic eofBit7Start, storeDone, txMabUnderflow, eccDataError, errorToListenOnlySelect, txBitstream;
   logic [31:0] fifoIsTx, rxFifoFullFlag, rxFifoHalfFlag, rxFifoNonemptyFlag, rxFullEnable, rxHalfEnable;
   logic [31:0] rxNonemptyEnable, txFifoNotFullFlag, txFifoHalfEmptyFlag, txFifoEmptyFlag, txNotFullEnable;
   logic [31:0] txHalfEmptyEnable, txEmptyEnable, rxOverrunEnable, txAttemptEnable, transmitRequest;
   logic [31:0] combinedReceiveFlags, combinedTransmitFlags, combinedReceiveOverrunFlags;
   logic [31:0] combinedTransmitAttemptFlags, transmitRequestGated;
   wire logic [31:0] rxOverrunClear, txAttemptClear;
   wire logic [12:0] mainClear;
   wire logic [4:0] devClear;
   wire logic eventFifoOverrunClear, spiFormatErrorClear, spiChecksumErrorClear, singleBitErrorClear;
   wire logic doubleBitErrorClear;
   fifo_index_t rxMessageFifo, txAttemptFifo;
   code_t interruptCodeField;
   logic [3:0] eventFifoEnable;
   logic [8:0] txErrorCount;
   logic [7:0] rxErrorCount;
   logic [2:0] currentOperatingMode;
   logic [12:0] mainEnable, mainFlags;
   logic spiFormatErrorFlag, spiChecksumErrorFlag, singleBitErrorFlag, doubleBitErrorFlag, eventFifoOverrunFlag;
   logic rxInterrupt, txInterrupt, infoInterrupt, fifoStatusUpdate, frameDiscard, restrictedMode;
   logic listenOnlyMode, busTransmitPin;
   // Any device-level sticky flag standing.
   wire logic anyDevFlag = spiFormatErrorFlag | spiChecksumErrorFlag | singleBitErrorFlag
      | doubleBitErrorFlag | eventFifoOverrunFlag;
   int n_fail, checks_done, updSeen, discSeen;
   int bitOf [8] = '{5, 6, 7, 8, 9, 11, 12, 4};
   logic [4:0] devOf [8] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h08, 5'h02, 5'h10};
   assign {eventFifoOverrunClear, spiFormatErrorClear, spiChecksumErrorClear, singleBitErrorClear,
      doubleBitErrorClear} = devClear;
   can_fd_interrupt_aggregator uut (.*);
   host_model host (.clk(clk), .mainClear(mainClear), .rxOverrunClear(rxOverrunClear),
      .txAttemptClear(txAttemptClear), .devClear(devClear));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // 25 MHz clock.
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   // Pulse outputs are counted, since their exact cycle is the design's choice.
   always @(posedge clk) begin
      if (fifoStatusUpdate === 1'h1) updSeen++;
      if (frameDiscard === 1'h1) discSeen++;
   end
   // The whole run takes some 90 cycles, so 4000 means a hang.
   initial begin
      repeat (4000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
   initial begin
      {queueNotFullFlag, queueEmptyFlag, queueNotFullEnable, rxMessageDone, txRetriesExhausted, eventFifoFullFlag,
         eventFifoHalfFlag, eventFifoNonemptyFlag, eventFifoOverrunEvent, spiFormatErrorEvent, spiChecksumErrorEvent,
         spiChecksumErrorEnable, singleBitErrorEvent, doubleBitErrorEvent, doubleBitErrorEnable, frameEnd, dlcMismatch,
         errorFrameSent, esiReceived, sleepMode, busActivity, timeBaseWrap, crcFieldStart, eofBit7Start, storeDone,
         txMabUnderflow, eccDataError, errorToListenOnlySelect, txBitstream} = '0;
      {rxFifoFullFlag, rxFifoHalfFlag, rxFifoNonemptyFlag, txFifoNotFullFlag, txFifoHalfEmptyFlag, txFifoEmptyFlag,
         rxOverrunEnable, txAttemptEnable, transmitRequest, rxMessageFifo, txAttemptFifo, txErrorCount,
         rxErrorCount, currentOperatingMode} = '0;
      {rxFullEnable, rxHalfEnable, rxNonemptyEnable, txNotFullEnable, txHalfEmptyEnable, txEmptyEnable} = '1;
      {queueEmptyEnable, spiFormatErrorEnable, singleBitErrorEnable} = 3'h7;
      fifoIsTx = 32'h0000_00f0;
      eventFifoEnable = 4'hf;
      mainEnable = 13'h1fff;
      rst = 1'h1;
      cyc(20);
      check("code", {busTransmitPin, interruptCodeField}, {1'h1, `CODE_NONE});
      rst = 1'h0;
      cyc(1);
      // Bit 0 of receive is reserved; FIFOs 4 to 7 are transmit.
      rxFifoFullFlag = 32'h8000_0009;
      rxFifoHalfFlag = 32'h0000_0014;
      txFifoHalfEmptyFlag = 32'h0000_0080;
      txFifoEmptyFlag = 32'h0000_0031;
      queueEmptyFlag = 1'h1;
      cyc(1);
      check("rxcomb", combinedReceiveFlags, 32'h8000_000c);
      check("txcomb", combinedTransmitFlags, 32'h0000_00b1);
      check("irq", {mainFlags[1:0], rxInterrupt, txInterrupt}, 4'hf);
      rxHalfEnable = 32'hffff_fffb;
      txEmptyEnable = 32'hffff_ffdf;
      queueEmptyEnable = 1'h0;
      cyc(1);
      check("rxen", combinedReceiveFlags, 32'h8000_0008);
      check("txen", combinedTransmitFlags, 32'h0000_0090);
      {rxFifoFullFlag, rxFifoHalfFlag, txFifoHalfEmptyFlag, txFifoEmptyFlag} = '0;
      queueEmptyFlag = 1'h0;
      cyc(1);
      check("lvl", {rxInterrupt, txInterrupt, |combinedReceiveFlags, |combinedTransmitFlags}, 4'h0);
      $display("levels done");
      rxFifoFullFlag = 32'h0000_0008;
      rxMessageFifo = 5'h03;
      rxMessageDone = 1'h1;
      txAttemptFifo = 5'h05;
      txRetriesExhausted = 1'h1;
      cyc(1);
      {rxMessageDone, rxFifoFullFlag} = '0;
      txAttemptFifo = 5'h00;
      cyc(1);
      txRetriesExhausted = 1'h0;
      cyc(2);
      check("ov", combinedReceiveOverrunFlags, 32'h0000_0008);
      check("at", combinedTransmitAttemptFlags, 32'h0000_0021);
      check("ovirq", {mainFlags[3:2], rxInterrupt}, 3'h7);
      host.clear(13'h0, 32'h0000_0008, 32'h0000_0021, 5'h0);
      check("ovclr", combinedReceiveOverrunFlags | combinedTransmitAttemptFlags | rxInterrupt, 32'h0);
      $display("overrun done");
      // A frame with the error state indicator set must not count as invalid.
      {errorFrameSent, esiReceived, frameEnd} = 3'h7;
      cyc(1);
      {errorFrameSent, esiReceived, frameEnd} = 3'h0;
      dlcMismatch = 1'h1;
      sleepMode = 1'h1;
      check("esi", mainFlags[5], 1'h0);
      for (int i = 0; i < 8; i++) begin
         case (i)
            0: frameEnd = 1'h1;
            1: busActivity = 1'h1;
            2: txErrorCount = 9'h060;
            3: currentOperatingMode = 3'h1;
            4: timeBaseWrap = 1'h1;
            5: spiFormatErrorEvent = 1'h1;
            6: singleBitErrorEvent = 1'h1;
            default: eventFifoOverrunEvent = 1'h1;
         endcase
         cyc(1);
         {frameEnd, busActivity, timeBaseWrap, spiFormatErrorEvent, singleBitErrorEvent, eventFifoOverrunEvent} = '0;
         cyc(2);
         check("ev", {mainFlags[bitOf[i]], anyDevFlag}, {1'h1, i > 4});
         check("evirq", infoInterrupt | txInterrupt, 1'h1);
         host.clear(13'h0001 << bitOf[i], 32'h0, 32'h0, devOf[i]);
         cyc(1);
         check("evclr", {mainFlags[bitOf[i]], anyDevFlag}, 2'h0);
         check("irqclr", {infoInterrupt, txInterrupt}, 2'h0);
      end
      $display("events done");
      transmitRequest = 32'h0000_00f0;
      txMabUnderflow = 1'h1;
      cyc(1);
      txMabUnderflow = 1'h0;
      check("serr", {mainFlags[10], interruptCodeField}, {1'h1, `CODE_SYSTEM_ERROR});
      check("blk", {busTransmitPin, restrictedMode, listenOnlyMode, transmitRequestGated[7:0]}, 11'h600);
      host.clear(13'h0400, 32'h0, 32'h0, 5'h0);
      check("unblk", {interruptCodeField, transmitRequestGated[7:0]}, {`CODE_NONE, 8'hf0});
      errorToListenOnlySelect = 1'h1;
      eccDataError = 1'h1;
      cyc(1);
      eccDataError = 1'h0;
      check("lom", {busTransmitPin, restrictedMode, listenOnlyMode}, 3'h5);
      host.clear(13'h0400, 32'h0, 32'h0, 5'h0);
      $display("system error done");
      // In the first pass the next frame reaches its CRC field before the stored one is written.
      for (int f = 0; f < 2; f++) begin
         crcFieldStart = 1'h1;
         cyc(1);
         crcFieldStart = 1'h0;
         cyc(2);
         eofBit7Start = 1'h1;
         cyc(1);
         eofBit7Start = 1'h0;
         crcFieldStart = (f == 0);
         cyc(1);
         crcFieldStart = 1'h0;
         cyc(2);
         storeDone = 1'h1;
         cyc(1);
         storeDone = 1'h0;
      end
      check("upd", updSeen, 2);
      check("disc", {discSeen[3:0], mainFlags[10], interruptCodeField}, {4'h1, 1'h1, `CODE_SYSTEM_ERROR});
      $display("receive done");
      give_verdict();
   end
endmodule
`default_nettype wire
